/* File: hdl/seepw_pkg.sv */
/*
 * Constants, state codes and timing for the two-wire serial EEPROM slave.
 * Assumes a 50 MHz core clock that oversamples the bus pins.
 */
package seepw_pkg;
    // Clock and programming time
    localparam int CLK_FREQ_HZ    = 50_000_000;
    localparam int WRITE_TIME_US  = 5000;
    localparam int WRITE_CYCLES   = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    // Array geometry
    localparam int ADDR_W         = 13;
    localparam int PAGE_BYTES     = 32;
    localparam int PAGE_W         = 5;
    // Slave address fixed pattern
    localparam logic [3:0] DEV_TYPE = 4'hA;
    // Byte positions within a transaction
    localparam logic [1:0] BYTE_DEV  = 2'h0;
    localparam logic [1:0] BYTE_HI   = 2'h1;
    localparam logic [1:0] BYTE_LO   = 2'h2;
    localparam logic [1:0] BYTE_DATA = 2'h3;
    // Bits per byte and synchroniser reset value
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] SYNC_RST      = 3'h7;
    // Transaction states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX   = 6'h02,
        ST_ACK  = 6'h04,
        ST_TX   = 6'h08,
        ST_MACK = 6'h10,
        ST_PROG = 6'h20
    } seepw_state_e;
endpackage

/* File: hdl/seepw_slave.sv */
/*
 * Two-wire serial EEPROM slave: page write with buffer, acknowledge polling,
 * current-address, random and sequential reads.
 * Assumes the bus master drives the clock line; both bus lines and the
 * address straps are oversampled by core_clk, which must run well above it.
 */
`timescale 1ns/10ps
module seepw_slave #(
    parameter int ADDR_W       = seepw_pkg::ADDR_W,
    parameter int WRITE_CYCLES = seepw_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Hard-wired address straps
    input  wire logic [2:0] addr_pins,
    // Busy indication
    output logic            busy
);
    localparam int DEPTH = 2 ** ADDR_W;

    // Two-stage synchronisers plus one delay stage for edges
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;

    // Transaction state
    seepw_pkg::seepw_state_e state_reg;
    logic [3:0]        bit_cnt_reg;         // Bits moved in current byte
    logic [1:0]        byte_idx_reg;        // Position, saturates at data
    logic [7:0]        rx_sh_reg;           // Receive shifter
    logic [7:0]        tx_sh_reg;           // Transmit shifter
    logic [7:0]        hi_reg;              // Upper word address byte
    logic              read_reg;            // Direction of current access
    logic [ADDR_W-1:0] ptr_reg;             // Internal address counter
    logic              oe_reg;              // Drives data line low
    logic [31:0]       prog_cnt_reg;        // Programming timer

    // Page buffer and storage array
    logic [7:0]            page_buf [0:seepw_pkg::PAGE_BYTES-1];
    logic [seepw_pkg::PAGE_BYTES-1:0] page_vld_reg;
    logic [7:0]            mem_arr  [0:DEPTH-1];

    // Bus event decode, on the second stage and its delayed copy only
    wire scl_now   = scl_sync_reg[1];
    wire scl_old   = scl_sync_reg[2];
    wire sda_now   = sda_sync_reg[1];
    wire sda_old   = sda_sync_reg[2];
    wire scl_rise  = scl_now & ~scl_old;
    wire scl_fall  = ~scl_now & scl_old;
    wire start_det = scl_now & scl_old & sda_old & ~sda_now;
    wire stop_det  = scl_now & scl_old & ~sda_old & sda_now;
    wire in_prog   = (state_reg == seepw_pkg::ST_PROG);

    // Byte complete decode
    wire byte_done = (state_reg == seepw_pkg::ST_RX) & scl_fall & (bit_cnt_reg == seepw_pkg::BITS_PER_BYTE);
    wire addr_ok   = (rx_sh_reg[7:4] == seepw_pkg::DEV_TYPE) & (rx_sh_reg[3:1] == pin_s2_reg);
    wire dev_ack   = byte_done & (byte_idx_reg == seepw_pkg::BYTE_DEV) & addr_ok;
    wire data_wr   = byte_done & (byte_idx_reg == seepw_pkg::BYTE_DATA) & ~read_reg;
    wire byte_ack  = byte_done & ((byte_idx_reg != seepw_pkg::BYTE_DEV) | addr_ok);
    wire tx_load   = (state_reg == seepw_pkg::ST_ACK) & scl_fall & read_reg &
                     (byte_idx_reg == seepw_pkg::BYTE_DEV); // Position moves on this same fall
    wire mack_next = (state_reg == seepw_pkg::ST_MACK) & scl_fall & ~rx_sh_reg[0];
    wire next_tx   = tx_load | mack_next;

    // Next word pointer: in-page wrap for writes, whole array for reads
    wire [ADDR_W-1:0] ptr_page_inc = {ptr_reg[ADDR_W-1:seepw_pkg::PAGE_W],
                                      ptr_reg[seepw_pkg::PAGE_W-1:0] + 5'h01};
    wire [ADDR_W-1:0] ptr_full_inc = ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
    wire [7:0]        rd_byte      = mem_arr[ptr_reg];
    wire [4:0]        sweep_idx    = prog_cnt_reg[4:0];
    wire              sweep_on     = in_prog & (prog_cnt_reg < 32'(seepw_pkg::PAGE_BYTES));
    wire              prog_done    = in_prog & (prog_cnt_reg == 32'(WRITE_CYCLES - 1));

    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;
    assign busy    = in_prog;

    // Synchronisers; stage one feeds stage two only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            scl_sync_reg <= seepw_pkg::SYNC_RST;
            sda_sync_reg <= seepw_pkg::SYNC_RST;
            pin_s1_reg   <= 3'h0;
            pin_s2_reg   <= 3'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            pin_s1_reg   <= addr_pins;
            pin_s2_reg   <= pin_s1_reg;
        end
    end

    // Transaction state machine
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg    <= seepw_pkg::ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= seepw_pkg::BYTE_DEV;
            oe_reg       <= 1'b0;
        end else if (in_prog) begin
            // Deaf to the bus until the timer expires
            oe_reg <= 1'b0;
            if (prog_done) begin
                state_reg <= seepw_pkg::ST_IDLE;  // Next address gets an ack
            end
        end else if (stop_det) begin
            // Programming only starts here, and only if bytes came in
            oe_reg    <= 1'b0;
            state_reg <= (|page_vld_reg) ? seepw_pkg::ST_PROG : seepw_pkg::ST_IDLE;
        end else if (start_det) begin
            // Start or repeated start resets the byte position
            oe_reg       <= 1'b0;
            state_reg    <= seepw_pkg::ST_RX;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= seepw_pkg::BYTE_DEV;
        end else begin
            case (state_reg)
                seepw_pkg::ST_RX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_ack) begin
                        oe_reg    <= 1'b1;
                        state_reg <= seepw_pkg::ST_ACK;
                    end else if (byte_done) begin
                        state_reg <= seepw_pkg::ST_IDLE; // Not our address
                    end
                end
                seepw_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (byte_idx_reg != seepw_pkg::BYTE_DATA) begin
                            byte_idx_reg <= byte_idx_reg + 2'h1;
                        end
                        if (tx_load) begin
                            oe_reg      <= ~rd_byte[7];
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= seepw_pkg::ST_TX;
                        end else begin
                            oe_reg    <= 1'b0;
                            state_reg <= seepw_pkg::ST_RX;
                        end
                    end
                end
                seepw_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == seepw_pkg::BITS_PER_BYTE) begin
                            oe_reg    <= 1'b0;           // Release for master ack
                            state_reg <= seepw_pkg::ST_MACK;
                        end else begin
                            oe_reg      <= ~tx_sh_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                seepw_pkg::ST_MACK: begin
                    if (scl_fall) begin
                        if (mack_next) begin
                            oe_reg      <= ~rd_byte[7];
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= seepw_pkg::ST_TX;
                        end else begin
                            state_reg <= seepw_pkg::ST_IDLE; // Nack
                        end
                    end
                end
                default: begin
                    state_reg <= seepw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Receive shifter; also samples the master ack bit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_sh_reg <= 8'h00;
        end else if (!in_prog && scl_rise) begin
            rx_sh_reg <= {rx_sh_reg[6:0], sda_now};
        end
    end

    // Transmit shifter
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_sh_reg <= 8'h00;
        end else if (!in_prog && !stop_det && !start_det && next_tx) begin
            tx_sh_reg <= rd_byte;
        end else if (state_reg == seepw_pkg::ST_TX && scl_fall) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end

    // Direction, address pointer and page buffer flags
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            read_reg     <= 1'b0;
            hi_reg       <= 8'h00;
            ptr_reg      <= '0;
            page_vld_reg <= '0;
        end else if (in_prog) begin
            if (prog_done) begin
                page_vld_reg <= '0;
            end
        end else if (start_det) begin
            page_vld_reg <= '0;
        end else if (!stop_det) begin
            if (dev_ack) begin
                read_reg <= rx_sh_reg[0];
            end
            if (byte_done && byte_idx_reg == seepw_pkg::BYTE_HI && !read_reg) begin
                hi_reg <= rx_sh_reg;
            end
            if (byte_done && byte_idx_reg == seepw_pkg::BYTE_LO && !read_reg) begin
                ptr_reg <= ADDR_W'({hi_reg, rx_sh_reg});
            end
            if (data_wr) begin
                page_vld_reg[ptr_reg[seepw_pkg::PAGE_W-1:0]] <= 1'b1;
                ptr_reg <= ptr_page_inc;
            end
            if (next_tx && state_reg != seepw_pkg::ST_RX) begin
                ptr_reg <= ptr_full_inc;
            end
        end
    end

    // Page buffer data; later bytes to the same slot replace earlier ones
    always_ff @(posedge core_clk) begin
        if (data_wr && !in_prog && !start_det && !stop_det) begin
            page_buf[ptr_reg[seepw_pkg::PAGE_W-1:0]] <= rx_sh_reg;
        end
    end

    // Programming timer; the first 32 cycles sweep the buffer into the array
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prog_cnt_reg <= 32'h0;
        end else if (in_prog) begin
            prog_cnt_reg <= prog_cnt_reg + 32'h1;
        end else begin
            prog_cnt_reg <= 32'h0;
        end
    end

    // Array commit; page base is the pointer's unchanged upper bits
    always_ff @(posedge core_clk) begin
        if (sweep_on && page_vld_reg[sweep_idx]) begin
            mem_arr[{ptr_reg[ADDR_W-1:seepw_pkg::PAGE_W], sweep_idx}] <= page_buf[sweep_idx];
        end
    end

    // Checks
    busy_no_drive_a: assert property (@(posedge core_clk) disable iff (reset)
        in_prog |-> ##1 !sda_oe)
        else $error("data line driven while programming");
    data_ack_a: assert property (@(posedge core_clk) disable iff (reset)
        data_wr && !start_det && !stop_det |=> sda_oe && state_reg == seepw_pkg::ST_ACK)
        else $error("write data byte not acknowledged");
    page_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
        data_wr && !start_det && !stop_det |=> ptr_reg[ADDR_W-1:5] == $past(ptr_reg[ADDR_W-1:5]) &&
        ptr_reg[4:0] == 5'($past(ptr_reg[4:0]) + 5'h01))
        else $error("page address did not wrap in page");
    prog_on_stop_a: assert property (@(posedge core_clk) disable iff (reset)
        !in_prog ##1 in_prog |-> $past(stop_det) && $past(|page_vld_reg))
        else $error("programming began without stop");
    prog_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        in_prog && prog_cnt_reg < 32'(WRITE_CYCLES - 1) |=> in_prog)
        else $error("programming ended early");
    addr_match_a: assert property (@(posedge core_clk) disable iff (reset)
        byte_done && byte_idx_reg == seepw_pkg::BYTE_DEV && !addr_ok && !start_det && !stop_det
        |=> state_reg == seepw_pkg::ST_IDLE && !sda_oe)
        else $error("foreign address acknowledged");
    read_inc_a: assert property (@(posedge core_clk) disable iff (reset)
        next_tx && !start_det && !stop_det && state_reg != seepw_pkg::ST_RX
        |=> ptr_reg == ADDR_W'($past(ptr_reg) + 1) && tx_sh_reg == $past(rd_byte))
        else $error("read counter did not advance");
    tx_msb_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == seepw_pkg::ST_TX && bit_cnt_reg == 4'h1 |-> sda_oe == !tx_sh_reg[7])
        else $error("first read bit wrong");

    page_write_c: cover property (@(posedge core_clk) disable iff (reset)
        data_wr ##[1:1000] $rose(in_prog));
    poll_busy_c: cover property (@(posedge core_clk) disable iff (reset)
        in_prog && start_det);
    seq_read_c: cover property (@(posedge core_clk) disable iff (reset)
        mack_next && !start_det && !stop_det);
endmodule

/* File: test/seepw_master_model.sv */
/*
 * Behavioural two-wire bus master that drives the EEPROM slave pins.
 * Assumes the bench resolves the data wire with a pull-up from all pull-downs.
 */
`timescale 1ns/10ps
module seepw_master_model (
    // Bus pins
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Clock stands high and data is released between frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Data changes only mid low phase, far from both clock edges
    task automatic bit_tx(input logic b);
        #40 sda_low = ~b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
    endtask
    // Sampled late in the high phase so the slow slave has settled
    task automatic bit_rx(output logic b);
        #40 sda_low = 1'b0;
        #40 scl = 1'b1;
        #60 b = sda;
        #20 scl = 1'b0;
    endtask
    // Start or repeated Start
    task automatic start();
        #40 sda_low = 1'b0;
        #40 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask
    // Stop leaves both lines high
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #80 sda_low = 1'b0;
        #160;
    endtask
    // Byte out, MSB first; returns the slave's acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_tx(d[i]);
        end
        bit_rx(a);
        ack = ~a;
    endtask
    // Byte in; the last wanted byte is left unacknowledged
    task automatic rd_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_rx(d[i]);
        end
        bit_tx(~more);
    endtask
endmodule

/* File: test/seepw_slave_tb.sv */
/*
 * Self-checking bench for the EEPROM slave with a reference memory model.
 * Assumes the master model in its own file and a shortened programming time.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module seepw_slave_tb;
    localparam int AW = 13;          // Same array size as the default
    localparam int WC = 200;         // Short programming time
    logic       core_clk = 1'b0;     // 50 MHz
    logic       reset;               // Active high
    logic       scl;                 // Bus clock from master
    logic       m_low;               // Master pull-down
    logic       sda_out;             // Slave drive level
    logic       sda_oe;              // Slave pull-down enable
    logic       busy;                // Programming flag
    logic [2:0] addr_pins;           // Straps
    wire logic  sda;                 // Resolved wire
    int         n_fail;
    int         checks;
    int         cyc = 0;             // Timeout counter
    int         ptr;                 // Model address counter
    logic [7:0] mem [int];           // Model array, written places only
    // Open drain with pull-up
    assign sda = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    seepw_slave #(.ADDR_W(AW), .WRITE_CYCLES(WC)) i_seepw_slave (
        .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins), .busy(busy));
    seepw_master_model i_seepw_master_model (.scl(scl), .sda_low(m_low), .sda(sda));
    // Clock
    always #10 core_clk = ~core_clk;
    // Hang guard, well above the roughly 6,600 cycles used
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Start plus slave address byte
    task automatic dev(input logic rd, input logic [3:0] kind, input logic [2:0] pins, output logic ack);
        i_seepw_master_model.start();
        i_seepw_master_model.wr_byte({kind, pins, rd}, ack);
    endtask
    // Address phase of a write or dummy write
    task automatic set_addr(input int a);
        logic ack;
        dev(1'b0, seepw_pkg::DEV_TYPE, addr_pins, ack);
        `CHK(ack, 1'b1)
        i_seepw_master_model.wr_byte(8'(a >> 8), ack);
        `CHK(ack, 1'b1)
        i_seepw_master_model.wr_byte(8'(a), ack);
        `CHK(ack, 1'b1)
    endtask
    // Page write, then acknowledge polling until done
    task automatic page_wr(input int a, input int n);
        logic       ack;
        logic [7:0] d;
        logic [7:0] pend [int];
        int         slot;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            slot = (a & ~31) | ((a + i) & 31);
            pend[slot] = d;
            i_seepw_master_model.wr_byte(d, ack);
            `CHK(ack, 1'b1)
        end
        `CHK(busy, 1'b0)
        i_seepw_master_model.stop();
        `CHK(busy, 1'b1)
        foreach (pend[k]) mem[k] = pend[k];
        ptr = (a & ~31) | ((a + n) & 31);
        // Still programming: no answer at all
        dev(1'b0, seepw_pkg::DEV_TYPE, addr_pins, ack);
        `CHK(ack, 1'b0)
        i_seepw_master_model.stop();
        for (int k = 0; k < 20 && !ack; k++) begin
            dev(1'b0, seepw_pkg::DEV_TYPE, addr_pins, ack);
            i_seepw_master_model.stop();
        end
        `CHK(ack, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    // Read n bytes; a below zero means from the current address
    task automatic rd_seq(input int a, input int n);
        logic       ack;
        logic [7:0] d;
        if (a >= 0) begin
            set_addr(a);
            ptr = a;
        end
        dev(1'b1, seepw_pkg::DEV_TYPE, addr_pins, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            i_seepw_master_model.rd_byte(i < n - 1, d);
            `CHK(d, mem[ptr])
            ptr = (ptr + 1) % (1 << AW);
        end
        i_seepw_master_model.stop();
    endtask
    // Main sequence
    initial begin
        logic       ack;
        logic [7:0] d;
        reset = 1'b1;
        addr_pins = 3'h0;
        n_fail = 0;
        checks = 0;
        ptr = $urandom(32'hDCE2E8CE);
        repeat (4) @(posedge core_clk);
        #2 reset = 1'b0;
        addr_pins = 3'($urandom);
        repeat (4) @(posedge core_clk);
        // Bus edges land just after a clock edge, never on it
        #2;
        page_wr(0, 3);
        page_wr(13'h1FFC, 40);
        rd_seq(-1, 1);
        rd_seq(13'h1FFE, 4);
        rd_seq(13'h1FFF, 1);
        rd_seq(-1, 2);
        // Every strap value and a wrong type nibble
        for (int p = 0; p < 8; p++) begin
            dev(1'b1, seepw_pkg::DEV_TYPE, 3'(p), ack);
            `CHK(ack, (3'(p) == addr_pins))
            if (ack) begin
                // Matching strap: current read carries on from the counter
                i_seepw_master_model.rd_byte(1'b0, d);
                `CHK(d, mem[ptr])
                ptr = (ptr + 1) % (1 << AW);
            end
            i_seepw_master_model.stop();
        end
        dev(1'b0, 4'hB, addr_pins, ack);
        `CHK(ack, 1'b0)
        i_seepw_master_model.stop();
        conclude();
    end
endmodule
